/* dmsp_consts.vh */
`ifndef DMSP_CONSTS_VH
`define DMSP_CONSTS_VH

// register byte addresses
`define DMSP_OFS_BUFFER 8'h00
`define DMSP_OFS_STATUS 8'h04
`define DMSP_OFS_CONTROL 8'h08
`define DMSP_OFS_FORMAT 8'h0C
`define DMSP_OFS_BAUD 8'h10
`define DMSP_OFS_REQUEST 8'h14

// reset values
`define DMSP_RST_CONTROL 8'h00
`define DMSP_RST_FORMAT 5'h00
`define DMSP_RST_BAUD 8'h00

// control bit positions
`define DMSP_CTL_EXTCLK 2
`define DMSP_CTL_RXEN 3
`define DMSP_CTL_TXEN 4
`define DMSP_CTL_SYNC 6
`define DMSP_CTL_ON 7

// format bit positions
`define DMSP_FMT_LEN7 0
`define DMSP_FMT_PAREN 1
`define DMSP_FMT_PARODD 2
`define DMSP_FMT_STOP2 3
`define DMSP_FMT_OPENDRAIN 4

// request bit positions
`define DMSP_REQ_TX 0
`define DMSP_REQ_RX 1

// index of the last of the 16 divider ticks in an asynchronous bit, and of the mid-bit tick
`define DMSP_OVERSAMPLE_LAST 4'hF
`define DMSP_MIDBIT 4'h7

`endif

/* dmsp_baud_div.v */
`timescale 1ns/100ps
`default_nettype none
module dmsp_baud_div (
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // control
  input wire run,
  input wire [7:0] divisor,
  // output
  output wire tick
);

  reg [7:0] count;

  // one tick every divisor+1 clocks
  assign tick = run & (count == 8'h00);

  always @(posedge sys_clk) begin
    if (!nrst) begin
      count <= 8'h00;
    end else if (!run) begin
      count <= divisor;
    end else if (count == 8'h00) begin
      count <= divisor;
    end else begin
      count <= count - 8'h01;
    end
  end

endmodule // dmsp_baud_div
`default_nettype wire

/* dmsp_serial_port.v */
`timescale 1ns/100ps
`default_nettype none
`include "dmsp_consts.vh"
module dmsp_serial_port (
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // transmit pin, two signals
  output reg transmitPin,
  output reg transmitPinOeN,
  // receive pin
  input wire receivePin,
  // serial clock pin, three signals
  input wire serialClkIn,
  output reg serialClkOut,
  output reg serialClkOeN,
  // request lines
  output reg txIrqReq,
  output reg rxIrqReq
);

  localparam TX_IDLE = 2'b01;
  localparam TX_BUSY = 2'b10;
  localparam RX_IDLE = 3'b001;
  localparam RX_START = 3'b010;
  localparam RX_DATA = 3'b100;

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg [7:0] control;
  reg [4:0] format;
  reg [7:0] baudN;
  reg [7:0] txBuf;
  reg txBufFull;
  reg [7:0] rxBuf;
  reg txEmptyF;
  reg rxFull;
  reg txDoneF;
  reg overrunF;
  reg parityF;
  reg framingF;
  reg sumF;

  wire chanOn = control[`DMSP_CTL_ON];
  wire syncMode = control[`DMSP_CTL_SYNC];
  wire txEn = control[`DMSP_CTL_TXEN];
  wire rxEn = control[`DMSP_CTL_RXEN];
  wire extClk = control[`DMSP_CTL_EXTCLK];
  wire len7 = format[`DMSP_FMT_LEN7];
  wire parEn = format[`DMSP_FMT_PAREN];
  wire parOdd = format[`DMSP_FMT_PARODD];
  wire stop2 = format[`DMSP_FMT_STOP2];
  wire openDrain = format[`DMSP_FMT_OPENDRAIN];

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  reg [31:0] next_prdata;
  reg next_hit;

  wire accessPh = psel & penable;
  wire setupPh = psel & ~penable;
  wire wrEn = accessPh & pwrite;
  wire rdEn = accessPh & ~pwrite;
  wire wrBuf = wrEn & (paddr == `DMSP_OFS_BUFFER);
  wire rdBuf = rdEn & (paddr == `DMSP_OFS_BUFFER);
  wire wrStat = wrEn & (paddr == `DMSP_OFS_STATUS);
  wire wrCtrl = wrEn & (paddr == `DMSP_OFS_CONTROL);
  wire wrFmt = wrEn & (paddr == `DMSP_OFS_FORMAT);
  wire wrBaud = wrEn & (paddr == `DMSP_OFS_BAUD);
  wire wrReq = wrEn & (paddr == `DMSP_OFS_REQUEST);
  wire chanOff = wrCtrl & ~pwdata[`DMSP_CTL_ON];

  // no wait states: read data is captured in the setup cycle
  assign pready = 1'b1;

  always @* begin
    next_prdata = 32'h0000_0000;
    next_hit = 1'b1;
    if (paddr == `DMSP_OFS_BUFFER) begin
      next_prdata = {24'h00_0000, rxBuf};
    end else if (paddr == `DMSP_OFS_STATUS) begin
      next_prdata = {25'h000_0000, sumF, framingF, parityF, overrunF,
        txDoneF, rxFull, txEmptyF};
    end else if (paddr == `DMSP_OFS_CONTROL) begin
      next_prdata = {24'h00_0000, control};
    end else if (paddr == `DMSP_OFS_FORMAT) begin
      next_prdata = {27'h000_0000, format};
    end else if (paddr == `DMSP_OFS_BAUD) begin
      next_prdata = {24'h00_0000, baudN};
    end else if (paddr == `DMSP_OFS_REQUEST) begin
      next_prdata = {30'h0000_0000, rxIrqReq, txIrqReq};
    end else begin
      next_hit = 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupPh) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= ~next_hit;
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      control <= `DMSP_RST_CONTROL;
      format <= `DMSP_RST_FORMAT;
      baudN <= `DMSP_RST_BAUD;
    end else begin
      if (wrCtrl) begin
        control <= pwdata[7:0];
      end
      if (wrFmt) begin
        format <= pwdata[4:0];
      end
      if (wrBaud) begin
        baudN <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  reg [1:0] rxMeta;
  reg [1:0] clkMeta;
  reg rxPrev;
  reg clkPrev;

  always @(posedge sys_clk) begin
    if (!nrst) begin
      rxMeta <= 2'b11;
      clkMeta <= 2'b11;
      rxPrev <= 1'b1;
      clkPrev <= 1'b1;
    end else begin
      rxMeta <= {rxMeta[0], receivePin};
      clkMeta <= {clkMeta[0], serialClkIn};
      rxPrev <= rxMeta[1];
      clkPrev <= clkMeta[1];
    end
  end

  wire rxIn = rxMeta[1];
  wire extFall = clkPrev & ~clkMeta[1];
  wire extRise = ~clkPrev & clkMeta[1];

  ////////////////////////////////////////////////////////////////////////
  // baud divider

  wire tick;

  dmsp_baud_div baudDiv (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(chanOn & ~wrBaud),
    .divisor(baudN),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // transmit / synchronous engine

  reg [1:0] txState;
  reg [11:0] txSr;
  reg [3:0] txBitsLeft;
  reg [3:0] txTickCnt;
  reg sclkReg;
  reg [3:0] syncCnt;
  reg [7:0] syncRxSr;

  wire txIdle = txState[0];
  wire txStart = txIdle & chanOn & txEn & txBufFull;
  wire txPar = ^(len7 ? {1'b0, txBuf[6:0]} : txBuf) ^ parOdd;
  wire [11:0] frm8 = parEn ? {2'b11, txPar, txBuf, 1'b0} :
    {3'b111, txBuf, 1'b0};
  wire [11:0] frm7 = parEn ? {3'b111, txPar, txBuf[6:0], 1'b0} :
    {4'b1111, txBuf[6:0], 1'b0};
  wire [3:0] frmLen = 4'd1 + (len7 ? 4'd7 : 4'd8) + {3'b000, parEn} +
    (stop2 ? 4'd2 : 4'd1);
  // common shift clock, ours or the partner's
  wire syncFall = extClk ? extFall : (tick & sclkReg);
  wire syncRise = extClk ? extRise : (tick & ~sclkReg);
  wire syncDone = txState[1] & syncMode & syncRise &
    (syncCnt == 4'd7);
  wire uartTxBit = tick & (txTickCnt == `DMSP_OVERSAMPLE_LAST);

  always @(posedge sys_clk) begin
    if (!nrst || chanOff || !chanOn) begin
      txState <= TX_IDLE;
      txSr <= 12'hFFF;
      txBitsLeft <= 4'h0;
      txTickCnt <= 4'h0;
      sclkReg <= 1'b1;
      syncCnt <= 4'h0;
      syncRxSr <= 8'h00;
    end else begin
      case (txState)
        TX_IDLE: begin
          sclkReg <= 1'b1;
          if (txStart) begin
            txState <= TX_BUSY;
            txTickCnt <= 4'h0;
            syncCnt <= 4'h0;
            if (syncMode) begin
              txSr <= {4'hF, txBuf};
              txBitsLeft <= 4'd8;
            end else begin
              txSr <= len7 ? frm7 : frm8;
              txBitsLeft <= frmLen;
            end
          end
        end
        TX_BUSY: begin
          if (syncMode) begin
            if (!extClk && tick) begin
              sclkReg <= ~sclkReg;
            end
            // first bit is already on the line before the first fall
            if (syncFall && syncCnt != 4'h0) begin
              txSr <= {1'b1, txSr[11:1]};
            end
            if (syncRise) begin
              syncRxSr <= {rxIn, syncRxSr[7:1]};
              syncCnt <= syncCnt + 4'h1;
              if (syncCnt == 4'd7) begin
                txState <= TX_IDLE;
              end
            end
          end else begin
            if (tick) begin
              txTickCnt <= txTickCnt + 4'h1;
            end
            if (uartTxBit) begin
              txSr <= {1'b1, txSr[11:1]};
              txBitsLeft <= txBitsLeft - 4'h1;
              if (txBitsLeft == 4'h1) begin
                txState <= TX_IDLE;
              end
            end
          end
        end
        default: begin
          txState <= TX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // asynchronous receiver

  reg [2:0] rxState;
  reg [3:0] rxTickCnt;
  reg [3:0] rxIdx;
  reg [9:0] rxSr;

  wire [3:0] rxStopIdx = (len7 ? 4'd7 : 4'd8) + {3'b000, parEn};
  wire rxBitTime = tick & (rxTickCnt == `DMSP_OVERSAMPLE_LAST);
  wire uartDone = rxState[2] & rxBitTime & (rxIdx == rxStopIdx);
  wire [7:0] uartData = len7 ? {1'b0, rxSr[6:0]} : rxSr[7:0];
  wire rxParBit = len7 ? rxSr[7] : rxSr[8];
  wire parBad = parEn & (^uartData ^ rxParBit ^ parOdd);
  wire frmBad = ~rxIn;

  always @(posedge sys_clk) begin
    if (!nrst || chanOff || !chanOn) begin
      rxState <= RX_IDLE;
      rxTickCnt <= 4'h0;
      rxIdx <= 4'h0;
      rxSr <= 10'h000;
    end else begin
      case (rxState)
        RX_IDLE: begin
          rxTickCnt <= 4'h0;
          rxIdx <= 4'h0;
          if (rxEn && !syncMode && rxPrev && !rxIn) begin
            rxState <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            rxTickCnt <= rxTickCnt + 4'h1;
            if (rxTickCnt == `DMSP_MIDBIT) begin
              rxTickCnt <= 4'h0;
              // a glitch shorter than half a bit is not a start
              rxState <= rxIn ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            rxTickCnt <= rxTickCnt + 4'h1;
          end
          if (rxBitTime) begin
            rxIdx <= rxIdx + 4'h1;
            if (rxIdx < 4'd10) begin
              rxSr[rxIdx] <= rxIn;
            end
            if (rxIdx == rxStopIdx) begin
              rxState <= RX_IDLE;
            end
          end
        end
        default: begin
          rxState <= RX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffers and status

  wire syncRxDone = syncDone & rxEn;
  wire rxDone = uartDone | syncRxDone;
  wire [7:0] rxData = syncMode ? {rxIn, syncRxSr[7:1]} : uartData;
  wire ovrNew = rxDone & rxFull & ~rdBuf;
  wire parNew = uartDone & parBad;
  wire frmNew = uartDone & frmBad;
  wire txEnRise = wrCtrl & pwdata[`DMSP_CTL_TXEN] & ~txEn;

  always @(posedge sys_clk) begin
    if (!nrst) begin
      txBuf <= 8'h00;
      txBufFull <= 1'b0;
      rxBuf <= 8'h00;
    end else if (chanOff) begin
      txBufFull <= 1'b0;
    end else begin
      // a new write keeps the buffer full even as the old byte loads
      if (wrBuf) begin
        txBuf <= pwdata[7:0];
        txBufFull <= 1'b1;
      end else if (txStart) begin
        txBufFull <= 1'b0;
      end
      if (rxDone) begin
        rxBuf <= rxData;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst || chanOff) begin
      txEmptyF <= 1'b0;
      rxFull <= 1'b0;
      txDoneF <= 1'b0;
      overrunF <= 1'b0;
      parityF <= 1'b0;
      framingF <= 1'b0;
      sumF <= 1'b0;
    end else begin
      txEmptyF <= txEn & ~txBufFull;
      txDoneF <= txEn & txIdle;
      if (rxDone) begin
        rxFull <= 1'b1;
      end else if (rdBuf) begin
        rxFull <= 1'b0;
      end
      // set wins over the status-write clear
      overrunF <= (overrunF & ~wrStat) | ovrNew;
      parityF <= (parityF & ~wrStat) | parNew;
      framingF <= (framingF & ~wrStat) | frmNew;
      sumF <= (sumF & ~wrStat) | ovrNew | parNew | frmNew;
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      txIrqReq <= 1'b0;
      rxIrqReq <= 1'b0;
    end else begin
      txIrqReq <= (txIrqReq & ~(wrReq & pwdata[`DMSP_REQ_TX])) |
        txStart | txEnRise;
      rxIrqReq <= (rxIrqReq & ~(wrReq & pwdata[`DMSP_REQ_RX])) | rxDone;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drivers

  wire txLine = txState[1] ? txSr[0] : 1'b1;

  always @(posedge sys_clk) begin
    if (!nrst) begin
      transmitPin <= 1'b1;
      transmitPinOeN <= 1'b1;
      serialClkOut <= 1'b1;
      serialClkOeN <= 1'b1;
    end else begin
      if (!(chanOn && txEn)) begin
        transmitPin <= 1'b1;
        transmitPinOeN <= 1'b1;
      end else if (openDrain) begin
        transmitPin <= 1'b0;
        transmitPinOeN <= txLine;
      end else begin
        transmitPin <= txLine;
        transmitPinOeN <= 1'b0;
      end
      serialClkOut <= sclkReg;
      serialClkOeN <= ~(chanOn & syncMode & ~extClk);
    end
  end

endmodule // dmsp_serial_port
`default_nettype wire

/* dmsp_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module dmsp_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // pins and requests
  input wire logic transmitPinOeN,
  input wire logic serialClkOeN,
  input wire logic txIrqReq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] ctl;
  logic [7:0] fmt;
  wire setupRd = psel && !penable && !pwrite;
  wire acc = psel && penable && pwrite;
  wire sOn = ctl[7] && ctl[6] && !ctl[2];
  // shadows follow software writes, so no hidden state is needed
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctl <= 8'h00;
      fmt <= 8'h00;
    end else if (acc && paddr == 8'h08) begin
      ctl <= pwdata[7:0];
    end else if (acc && paddr == 8'h0C) begin
      fmt <= pwdata[7:0];
    end
  end
  sequence stsClr;
    acc && paddr == 8'h04;
  endsequence
  sequence stsRd;
    setupRd && paddr == 8'h04;
  endsequence
  ////////////////////////////////////////
  pready_const_a: assert property (pready)
    else $error("pready low");
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h14
    |=> pslverr) else $error("no error on unmapped address");
  mapped_ok_a: assert property (psel && !penable && paddr <= 8'h14
    && paddr[1:0] == 2'b00 |=> !pslverr) else $error("error on register");
  status_width_a: assert property (stsRd
    |=> prdata[31:7] == 25'h0) else $error("status bit 7 up not zero");
  sum_flag_a: assert property (stsRd
    |=> prdata[6] == |prdata[5:3]) else $error("sum flag wrong");
  err_clear_a: assert property (stsClr ##[1:2] stsRd
    |=> prdata[6:3] == 4'h0) else $error("errors not cleared");
  off_status_a: assert property (stsRd and !ctl[7]
    |=> prdata[7:0] == 8'h00) else $error("status set while off");
  txen_irq_a: assert property (acc && paddr == 8'h08 && pwdata[4]
    && !ctl[4] |=> txIrqReq) else $error("tx request not set");
  short_msb_a: assert property (setupRd && paddr == 8'h00 && fmt[0]
    && !ctl[6] |=> !prdata[7]) else $error("7-bit char msb set");
  clk_drive_a: assert property (!serialClkOeN
    |-> sOn || $past(sOn)) else $error("clock pin driven");
  reset_idle_a: assert property (disable iff (1'b0) !nrst
    |=> transmitPinOeN && serialClkOeN && !txIrqReq)
    else $error("outputs not idle in reset");
endmodule // dmsp_sva
`default_nettype wire

/* dmsp_remote.sv */
`timescale 1ns/100ps
`default_nettype none
module dmsp_remote (
  // clock
  input wire logic sys_clk,
  // line from the device, line to it
  input wire logic lineIn,
  output logic lineOut
);
  int bitClks = 16;
  int rxLen = 10;
  logic [11:0] got[$];
  logic [11:0] v;
  initial lineOut = 1'b1;
  // mid-bit sampling; a second stop bit is not kept
  always begin
    @(negedge lineIn);
    repeat (bitClks / 2) @(posedge sys_clk);
    v = 12'h000;
    for (int i = 0; i < rxLen; i++) begin
      repeat (bitClks) @(posedge sys_clk);
      v[i] = lineIn;
    end
    got.push_back(v);
  end
  ////////////////////////////////////////
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      lineOut <= f[i];
      repeat (bitClks) @(posedge sys_clk);
    end
  endtask
endmodule // dmsp_remote
`default_nettype wire

/* dmsp_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic serialClkIn = 1'b1;
  wire pready, pslverr, transmitPin, transmitPinOeN, rxLine;
  wire serialClkOut, serialClkOeN, txIrqReq, rxIrqReq;
  wire [31:0] prdata;
  // pull-up keeps the line high whenever the pin is released
  wire txLine = transmitPinOeN ? 1'b1 : transmitPin;
  integer seed;
  int n, k, len, checked, mismatches;
  logic [31:0] rd;
  logic err, bad, lastClk;
  logic [7:0] d, sh, fm;
  logic [11:0] w;
  always #2 sys_clk = ~sys_clk;
  dmsp_serial_port i_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .transmitPin(transmitPin), .transmitPinOeN(transmitPinOeN),
    .receivePin(rxLine), .serialClkIn(serialClkIn),
    .serialClkOut(serialClkOut), .serialClkOeN(serialClkOeN),
    .txIrqReq(txIrqReq), .rxIrqReq(rxIrqReq));
  dmsp_remote i_remote (.sys_clk(sys_clk), .lineIn(txLine),
    .lineOut(rxLine));
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic limit(input int i, input int lim);
    if (i >= lim) begin
      mismatches++;
      give_verdict();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ends on a falling edge so callers sample settled outputs
  task automatic apb(input logic wr, input logic [7:0] a, ws);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, ws};
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1)
        break;
    end
    limit(i, 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge sys_clk);
  endtask
  // expected frame: start, data lsb first, parity, stops
  function automatic logic [11:0] frame(input logic [7:0] dd,
      input logic [3:0] f, input logic bd, output int ln);
    logic [11:0] x;
    x = 12'hFFF;
    x[0] = 1'b0;
    for (int i = 0; i < 8 - f[0]; i++)
      x[i + 1] = dd[i];
    ln = 9 - f[0];
    if (f[1]) begin
      x[ln] = ^(dd & (f[0] ? 8'h7F : 8'hFF)) ^ f[2] ^ bd;
      ln++;
    end
    ln = ln + 1 + f[3];
    return x;
  endfunction
  ////////////////////////////////////////
  initial begin
    seed = 59152;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (w[i]) begin
      if (i > 0 && i < 5) begin
        apb(1'b0, 8'(i * 4), 8'h00);
        chk("reset value", 32'h0000_0000, rd);
      end
    end
    apb(1'b0, 8'h18, 8'h00);
    chk("unmapped error", 32'h0000_0001, {31'h0, err});
    for (int f = 0; f < 16; f++) begin
      n = $unsigned($random(seed)) % 4;
      i_remote.bitClks = 16 * (n + 1);
      fm = {3'b000, f[0], f[3:0]};
      apb(1'b1, 8'h10, 8'(n));
      apb(1'b1, 8'h0C, fm);
      apb(1'b0, 8'h0C, 8'h00);
      chk("format", {24'h00_0000, fm}, rd);
      apb(1'b1, 8'h14, 8'h03);
      chk("tx request", 32'h0000_0000, {31'h0, txIrqReq});
      apb(1'b1, 8'h08, 8'h98);
      chk("tx request", 32'h0000_0001, {31'h0, txIrqReq});
      apb(1'b0, 8'h04, 8'h00);
      chk("status", 32'h0000_0005, rd);
      d = $random(seed);
      w = frame(d, f[3:0], 1'b0, len);
      i_remote.rxLen = len - 1 - f[3];
      apb(1'b1, 8'h00, d);
      for (k = 0; k < 5000 && i_remote.got.size() == 0; k++)
        @(posedge sys_clk);
      limit(k, 5000);
      chk("tx frame", (w >> 1) & ((12'h001 << i_remote.rxLen) - 1),
        i_remote.got.pop_front());
      d = $random(seed);
      bad = f[0] & f[1];
      w = frame(d, f[3:0], bad, len);
      i_remote.send(w, len);
      chk("rx request", 32'h0000_0001, {31'h0, rxIrqReq});
      apb(1'b0, 8'h04, 8'h00);
      chk("status", bad ? 32'h0000_0057 : 32'h0000_0007, rd);
      apb(1'b0, 8'h00, 8'h00);
      chk("rx data", {24'h00_0000, d & (f[0] ? 8'h7F : 8'hFF)}, rd);
      apb(1'b0, 8'h04, 8'h00);
      chk("status", bad ? 32'h0000_0055 : 32'h0000_0005, rd);
      apb(1'b1, 8'h04, 8'h00);
      apb(1'b0, 8'h04, 8'h00);
      chk("status", 32'h0000_0005, rd);
      apb(1'b1, 8'h08, 8'h00);
      apb(1'b0, 8'h04, 8'h00);
      chk("status", 32'h0000_0000, rd);
    end
    apb(1'b1, 8'h10, 8'h00);
    apb(1'b1, 8'h08, 8'hD8);
    apb(1'b1, 8'h00, 8'hA5);
    chk("clock drive", 32'h0000_0000, {31'h0, serialClkOeN});
    k = 0;
    lastClk = 1'b1;
    for (int i = 0; i < 400; i++) begin
      @(negedge sys_clk);
      if (serialClkOut && !lastClk) begin
        k++;
        sh = {txLine, sh[7:1]};
      end
      lastClk = serialClkOut;
    end
    chk("shift clocks", 32'h0000_0008, 32'(k));
    chk("sync tx data", 32'h0000_00A5, {24'h00_0000, sh});
    apb(1'b0, 8'h00, 8'h00);
    chk("sync rx data", 32'h0000_00FF, rd);
    // partner clocks the next byte and sends its own byte back
    apb(1'b1, 8'h08, 8'hDC);
    d = $random(seed);
    fm = $random(seed);
    apb(1'b1, 8'h00, d);
    chk("clock release", 32'h0000_0001, {31'h0, serialClkOeN});
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      serialClkIn <= 1'b0;
      i_remote.lineOut <= fm[i];
      // low and high phases outlast the pin synchronisers
      repeat (6) @(posedge sys_clk);
      sh = {txLine, sh[7:1]};
      serialClkIn <= 1'b1;
      repeat (5) @(posedge sys_clk);
    end
    i_remote.lineOut <= 1'b1;
    chk("ext tx data", {24'h00_0000, d}, {24'h00_0000, sh});
    apb(1'b0, 8'h00, 8'h00);
    chk("ext rx data", {24'h00_0000, fm}, rd);
    give_verdict();
  end
endmodule // tb
bind dmsp_serial_port dmsp_sva i_sva (.sys_clk(sys_clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .transmitPinOeN(transmitPinOeN), .serialClkOeN(serialClkOeN),
  .txIrqReq(txIrqReq));
`default_nettype wire
